// file: design/parallel_capture_port.sv
// parallel capture port: fifo and port engine
// Functional notes
// - port clock, three frame syncs, sixteen data
// - frame sync drive chosen by configuration
// - general modes move data one way
// - video modes move 8 or 10 bits
// - embedded preambles decoded in hardware
// - input mode: syncs and data are received
// - frame capture drives syncs, receives data
// - capture: sync one horizontal, two vertical
// - output mode drives data and syncs
// - input mode starts on frame sync one
// - start delay in port clocks before sampling
// - sample count samples per frame sync
// - width 8 or 10 to 16 bits
// - active mode drops blanking samples
// - active mode strips control sequences
// - active mode syncs field one, waits SAV
// - active mode counts active lines
// - blanking mode passes vertical blanking only
// - entire field mode passes every sample
// - entire field starts at field one
`timescale 1ns/100ps
`include "pcp_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module pcp_fifo
    import pcp_pkg::*;
#(
    parameter int WIDTH = `PCP_DW,
    parameter int DEPTH = `PCP_FIFO_DEPTH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             flush_i,
    input  wire logic             wr_valid_i,
    output logic                  wr_ready_o,
    input  wire logic [WIDTH-1:0] wr_data_i,
    output logic                  rd_valid_o,
    input  wire logic             rd_ready_i,
    output logic [WIDTH-1:0]      rd_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0]      wptr_ff;
    logic [AW:0]      rptr_ff;
    wire              full  = (wptr_ff[AW] != rptr_ff[AW]) && (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]);
    wire              empty = (wptr_ff == rptr_ff);
    wire              do_wr = wr_valid_i && !full;
    wire              do_rd = rd_ready_i && !empty;

    assign wr_ready_o = !full;
    assign rd_valid_o = !empty;
    assign rd_data_o  = mem_ff[rptr_ff[AW-1:0]];

    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem_ff[wptr_ff[AW-1:0]] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
        end else if (flush_i) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
        end else begin
            wptr_ff <= wptr_ff + (AW+1)'(do_wr);
            rptr_ff <= rptr_ff + (AW+1)'(do_rd);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
module parallel_capture_port
    import pcp_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 port_clock_in_i,
    input  wire logic [`PCP_FS_N-1:0] frame_sync_i,
    output logic [`PCP_FS_N-1:0]      frame_sync_o,
    output logic [`PCP_FS_N-1:0]      frame_sync_oe_o,
    input  wire logic [`PCP_DW-1:0]   data_i,
    output logic [`PCP_DW-1:0]        data_o,
    output logic [`PCP_DW-1:0]        data_oe_o,
    input  wire logic                 port_enable_i,
    input  wire logic [2:0]           port_mode_i,
    input  wire logic [2:0]           data_width_i,
    input  wire logic [`PCP_FS_N-1:0] fs_drive_en_i,
    input  wire logic [`PCP_CW-1:0]   start_delay_reg_i,
    input  wire logic [`PCP_CW-1:0]   sample_count_reg_i,
    input  wire logic [`PCP_CW-1:0]   line_length_i,
    input  wire logic [`PCP_CW-1:0]   frame_lines_i,
    output logic                      rx_valid_o,
    input  wire logic                 rx_ready_i,
    output logic [`PCP_DW-1:0]        rx_data_o,
    input  wire logic                 tx_valid_i,
    output logic                      tx_ready_o,
    input  wire logic [`PCP_DW-1:0]   tx_data_i,
    output logic                      frame_done_o,
    output logic                      overrun_o,
    output logic                      underrun_o,
    output logic                      field_locked_o
);
    // width code 0 is 8 bits, code k is 9+k bits
    function automatic logic [`PCP_DW-1:0] width_mask(input logic [2:0] code);
        logic [4:0] bits;
        bits = (code == `PCP_WID_8) ? 5'h08 : (`PCP_WID_BASE + {2'h0, code});
        width_mask = `PCP_DW'((17'h1 << bits) - 17'h1);
    endfunction

    function automatic logic [7:0] video_word(input logic [`PCP_DW-1:0] d,
                                              input logic [2:0] code);
        video_word = (code == `PCP_WID_10) ? d[9:2] : d[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pins are asynchronous to clk_i; port clock is at most half of clk_i
    localparam int SW = 1 + `PCP_FS_N + `PCP_DW;
    logic [SW-1:0]         sync1_ff;
    logic [SW-1:0]         sync2_ff;
    logic                  pclk_prev_ff;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff     <= '0;
            sync2_ff     <= '0;
            pclk_prev_ff <= 1'b0;
        end else begin
            sync1_ff     <= {port_clock_in_i, frame_sync_i, data_i};
            sync2_ff     <= sync1_ff;
            pclk_prev_ff <= sync2_ff[SW-1];
        end
    end

    wire                   pclk_edge = sync2_ff[SW-1] && !pclk_prev_ff;
    wire [`PCP_FS_N-1:0]   samp_fs   = sync2_ff[`PCP_DW +: `PCP_FS_N];
    wire [`PCP_DW-1:0]     mask      = width_mask(data_width_i);
    wire [`PCP_DW-1:0]     samp_data = sync2_ff[`PCP_DW-1:0] & mask;
    wire [7:0]             vword     = video_word(sync2_ff[`PCP_DW-1:0], data_width_i);

    pcp_mode_type          mode;
    assign mode = pcp_mode_type'(port_mode_i);
    wire                   is_itu  = (mode == PCP_ITU_ACTIVE) || (mode == PCP_ITU_VBI)
                                     || (mode == PCP_ITU_FIELD);
    wire                   is_gen  = (mode == PCP_GP_CAPTURE) || (mode == PCP_GP_OUT);
    wire                   in_dir  = (mode != PCP_GP_OUT);

    ////////////////////////////////////////////////////////////////////////////
    // frame sync generator for capture and output modes
    logic [`PCP_CW-1:0]    hcnt_ff;
    logic [`PCP_CW-1:0]    vcnt_ff;
    logic                  fs1_in_prev_ff;
    wire                   h_last = (hcnt_ff + `PCP_CNT_ONE) >= line_length_i;
    wire                   v_last = (vcnt_ff + `PCP_CNT_ONE) >= frame_lines_i;
    wire [`PCP_FS_N-1:0]   nxt_fs = {hcnt_ff == `PCP_CNT_ZERO && vcnt_ff == `PCP_CNT_ZERO,
                                     vcnt_ff == `PCP_CNT_ZERO,
                                     hcnt_ff == `PCP_CNT_ZERO};
    logic [`PCP_FS_N-1:0]  fs_out_ff;
    logic [`PCP_FS_N-1:0]  fs_oe_ff;
    logic [`PCP_FS_N-1:0]  nxt_fs_oe;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hcnt_ff        <= '0;
            vcnt_ff        <= '0;
            fs_out_ff      <= '0;
            fs1_in_prev_ff <= 1'b0;
        end else if (!port_enable_i || !is_gen) begin
            hcnt_ff        <= '0;
            vcnt_ff        <= '0;
            fs_out_ff      <= '0;
            fs1_in_prev_ff <= pclk_edge ? samp_fs[0] : fs1_in_prev_ff;
        end else if (pclk_edge) begin
            fs_out_ff <= nxt_fs;
            hcnt_ff   <= h_last ? '0 : hcnt_ff + `PCP_CNT_ONE;
            if (h_last) begin
                vcnt_ff <= v_last ? '0 : vcnt_ff + `PCP_CNT_ONE;
            end
        end
    end

    // pin direction per line: capture forces lines one and two out
    genvar gi;
    generate
        for (gi = 0; gi < `PCP_FS_N; gi++) begin : g_fs_dir
            assign nxt_fs_oe[gi] = port_enable_i && (fs_drive_en_i[gi]
                                   && is_gen || (mode == PCP_GP_CAPTURE && gi < 2));
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fs_oe_ff <= '0;
        end else begin
            fs_oe_ff <= nxt_fs_oe;
        end
    end

    assign frame_sync_o    = fs_out_ff;
    assign frame_sync_oe_o = fs_oe_ff;

    ////////////////////////////////////////////////////////////////////////////
    // embedded preamble decoder: ones, zero, zero, code word
    logic [1:0]            pre_ff;
    logic                  f_ff;
    logic                  v_ff;
    logic                  h_ff;
    logic [1:0]            nxt_pre;
    wire                   code_now  = (pre_ff == `PCP_PRE_CODE);
    wire                   is_ctrl   = (vword == `PCP_WORD_ONES) || (pre_ff != `PCP_PRE_NONE);
    wire                   field_one = code_now && !vword[`PCP_XY_F] && f_ff;
    wire                   end_line  = code_now && vword[`PCP_XY_H] && !v_ff && !h_ff;

    always_comb begin
        nxt_pre = `PCP_PRE_NONE;
        if (vword == `PCP_WORD_ONES) begin
            nxt_pre = `PCP_PRE_ONES;
        end else if (vword == `PCP_WORD_ZERO && pre_ff == `PCP_PRE_ONES) begin
            nxt_pre = `PCP_PRE_ZERO1;
        end else if (vword == `PCP_WORD_ZERO && pre_ff == `PCP_PRE_ZERO1) begin
            nxt_pre = `PCP_PRE_CODE;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_ff <= `PCP_PRE_NONE;
            f_ff   <= 1'b0;
            v_ff   <= 1'b1;
            h_ff   <= 1'b1;
        end else if (!port_enable_i || !is_itu) begin
            pre_ff <= `PCP_PRE_NONE;
        end else if (pclk_edge) begin
            pre_ff <= nxt_pre;
            if (code_now) begin
                f_ff <= vword[`PCP_XY_F];
                v_ff <= vword[`PCP_XY_V];
                h_ff <= vword[`PCP_XY_H];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transfer sequencer
    pcp_state_type         state_ff;
    pcp_state_type         nxt_state;
    logic [`PCP_CW-1:0]    dly_ff;
    logic [`PCP_CW-1:0]    rem_ff;
    logic [`PCP_CW-1:0]    nxt_dly;
    logic [`PCP_CW-1:0]    nxt_rem;
    logic                  nxt_done;
    logic                  done_ff;

    wire fs1_rise  = samp_fs[0] && !fs1_in_prev_ff;
    wire gp_trig   = (mode == PCP_GP_IN) ? fs1_rise : (is_gen && h_last == 1'b0 &&
                     hcnt_ff == `PCP_CNT_ZERO);
    wire xfer_edge = pclk_edge && (state_ff == PCP_ST_XFER);
    wire pass_itu  = (mode == PCP_ITU_FIELD) ||
                     (mode == PCP_ITU_ACTIVE && !v_ff && !h_ff && !is_ctrl) ||
                     (mode == PCP_ITU_VBI && v_ff && !is_ctrl);
    wire lines_end = (mode == PCP_ITU_ACTIVE) && end_line
                     && (rem_ff == `PCP_CNT_ONE);

    always_comb begin
        nxt_state = state_ff;
        nxt_dly   = dly_ff;
        nxt_rem   = rem_ff;
        nxt_done  = 1'b0;
        case (state_ff)
            PCP_ST_IDLE: begin
                nxt_state = PCP_ST_WAIT;
            end
            PCP_ST_WAIT: begin
                nxt_rem = sample_count_reg_i;
                nxt_dly = start_delay_reg_i;
                if (is_itu && field_one) begin
                    nxt_state = PCP_ST_XFER;
                end else if (!is_itu && gp_trig && sample_count_reg_i != `PCP_CNT_ZERO) begin
                    nxt_state = (start_delay_reg_i == `PCP_CNT_ZERO) ? PCP_ST_XFER
                                                                     : PCP_ST_DELAY;
                end
            end
            PCP_ST_DELAY: begin
                nxt_dly = dly_ff - `PCP_CNT_ONE;
                if (dly_ff == `PCP_CNT_ONE) begin
                    nxt_state = PCP_ST_XFER;
                end
            end
            PCP_ST_XFER: begin
                if (is_itu) begin
                    if (mode == PCP_ITU_ACTIVE && end_line) begin
                        nxt_rem = rem_ff - `PCP_CNT_ONE;
                    end
                    if (lines_end) begin
                        nxt_state = PCP_ST_WAIT;
                        nxt_done  = 1'b1;
                    end
                end else begin
                    nxt_rem = rem_ff - `PCP_CNT_ONE;
                    if (rem_ff == `PCP_CNT_ONE) begin
                        nxt_state = PCP_ST_WAIT;
                        nxt_done  = 1'b1;
                    end
                end
            end
            default: begin
                nxt_state = PCP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff <= PCP_ST_IDLE;
            dly_ff   <= '0;
            rem_ff   <= '0;
            done_ff  <= 1'b0;
        end else if (!port_enable_i) begin
            state_ff <= PCP_ST_IDLE;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= pclk_edge && nxt_done;
            if (pclk_edge) begin
                state_ff <= nxt_state;
                dly_ff   <= nxt_dly;
                rem_ff   <= nxt_rem;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data path through the fifo; direction picks its filler and drainer
    logic                  fifo_wr_ready;
    logic                  fifo_rd_valid;
    logic [`PCP_DW-1:0]    fifo_rd_data;
    logic [`PCP_DW-1:0]    dout_ff;
    logic [`PCP_DW-1:0]    doe_ff;
    logic                  ovr_ff;
    logic                  und_ff;

    wire cap_push  = xfer_edge && in_dir && (is_itu ? pass_itu : 1'b1);
    wire out_slot  = xfer_edge && (mode == PCP_GP_OUT);
    wire out_pop   = out_slot && fifo_rd_valid;
    wire fifo_wr_v = in_dir ? cap_push : (tx_valid_i && port_enable_i);
    wire fifo_rd_r = in_dir ? rx_ready_i : out_pop;

    // the port cannot be stalled: a full fifo drops the sample and flags it
    pcp_fifo #(
        .WIDTH (`PCP_DW),
        .DEPTH (`PCP_FIFO_DEPTH)
    ) u_fifo (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .flush_i    (!port_enable_i),
        .wr_valid_i (fifo_wr_v),
        .wr_ready_o (fifo_wr_ready),
        .wr_data_i  (in_dir ? samp_data : tx_data_i),
        .rd_valid_o (fifo_rd_valid),
        .rd_ready_i (fifo_rd_r),
        .rd_data_o  (fifo_rd_data)
    );

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dout_ff <= '0;
            doe_ff  <= '0;
            ovr_ff  <= 1'b0;
            und_ff  <= 1'b0;
        end else begin
            doe_ff <= (port_enable_i && mode == PCP_GP_OUT) ? mask : '0;
            ovr_ff <= cap_push && !fifo_wr_ready;
            und_ff <= out_slot && !fifo_rd_valid;
            if (out_pop) begin
                dout_ff <= fifo_rd_data & mask;
            end
        end
    end

    assign data_o         = dout_ff;
    assign data_oe_o      = doe_ff;
    assign rx_valid_o     = in_dir && fifo_rd_valid;
    assign rx_data_o      = fifo_rd_data;
    assign tx_ready_o     = !in_dir && port_enable_i && fifo_wr_ready;
    assign frame_done_o   = done_ff;
    assign overrun_o      = ovr_ff;
    assign underrun_o     = und_ff;
    assign field_locked_o = is_itu && (state_ff == PCP_ST_XFER);

    ////////////////////////////////////////////////////////////////////////////
    sequence s_field_one_found;
        pclk_edge && port_enable_i && state_ff == PCP_ST_WAIT && is_itu && field_one;
    endsequence

    sequence s_last_sample;
        pclk_edge && port_enable_i && state_ff == PCP_ST_XFER && !is_itu
        && rem_ff == `PCP_CNT_ONE;
    endsequence

    AST_FIELD_START: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_field_one_found |=> state_ff == PCP_ST_XFER)
        else $error("transfer did not start at field one");

    AST_COUNT_END: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_last_sample |=> state_ff == PCP_ST_WAIT ##0 frame_done_o)
        else $error("sample count not honoured");

    AST_DELAY_END: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pclk_edge && port_enable_i && state_ff == PCP_ST_DELAY && dly_ff == `PCP_CNT_ONE
        |=> state_ff == PCP_ST_XFER)
        else $error("start delay ended at wrong edge");

    AST_DELAY_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pclk_edge && port_enable_i && state_ff == PCP_ST_WAIT && nxt_state == PCP_ST_DELAY
        |=> dly_ff == $past(start_delay_reg_i))
        else $error("start delay not loaded");

    AST_INPUT_NO_DRIVE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        mode == PCP_GP_IN ##1 mode == PCP_GP_IN |-> frame_sync_oe_o == '0 && data_oe_o == '0)
        else $error("input mode drives a pin");

    AST_CAPTURE_SYNCS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        port_enable_i && mode == PCP_GP_CAPTURE |=> frame_sync_oe_o[1:0] == 2'h3
        && data_oe_o == '0)
        else $error("capture mode sync direction wrong");

    AST_OUT_DATA: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        out_pop |=> data_o == ($past(fifo_rd_data) & $past(mask)))
        else $error("output word not launched");

    AST_STRIP_CTRL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cap_push && mode == PCP_ITU_ACTIVE |-> !is_ctrl && !v_ff && !h_ff)
        else $error("control word or blanking stored in active mode");

    AST_VBI_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cap_push && mode == PCP_ITU_VBI |-> v_ff)
        else $error("non blanking sample stored");

    AST_LINES_END: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pclk_edge && port_enable_i && state_ff == PCP_ST_XFER && lines_end
        |=> state_ff == PCP_ST_WAIT)
        else $error("active line count not honoured");

    AST_EDGE_SPACING: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pclk_edge |=> !pclk_edge)
        else $error("port clock edges back to back");
endmodule

// file: design/pcp_cfg.svh
// constants for the parallel capture port
`ifndef PCP_CFG_SVH
`define PCP_CFG_SVH
`define PCP_DW          16
`define PCP_CW          16
`define PCP_FIFO_DEPTH  8
`define PCP_FS_N        3
`define PCP_SYS_NS      8
`define PCP_MIN_PCLK_CYC 2
`define PCP_WORD_ONES   8'hFF
`define PCP_WORD_ZERO   8'h00
`define PCP_XY_F        6
`define PCP_XY_V        5
`define PCP_XY_H        4
`define PCP_WID_8       3'h0
`define PCP_WID_10      3'h1
`define PCP_WID_BASE    5'h09
`define PCP_PRE_NONE    2'h0
`define PCP_PRE_ONES    2'h1
`define PCP_PRE_ZERO1   2'h2
`define PCP_PRE_CODE    2'h3
`define PCP_CNT_ONE     16'h0001
`define PCP_CNT_ZERO    16'h0000
`endif

// file: design/pcp_pkg.sv
// types for the parallel capture port
package pcp_pkg;
    typedef enum logic [2:0] {
        PCP_GP_IN      = 3'h0,
        PCP_GP_CAPTURE = 3'h1,
        PCP_GP_OUT     = 3'h2,
        PCP_ITU_ACTIVE = 3'h3,
        PCP_ITU_VBI    = 3'h4,
        PCP_ITU_FIELD  = 3'h5
    } pcp_mode_type;

    typedef enum logic [1:0] {
        PCP_ST_IDLE  = 2'h0,
        PCP_ST_WAIT  = 2'h1,
        PCP_ST_DELAY = 2'h3,
        PCP_ST_XFER  = 2'h2
    } pcp_state_type;
endpackage

// file: bench/pcp_far_model.sv
// far-side converter model: port clock, frame syncs and data words
`timescale 1ns/100ps
module pcp_far_model (
    output logic        pclk_o,
    output logic [2:0]  fs_o,
    output logic [15:0] dat_o
);
    logic active;
    initial begin
        active = 1'b0;
        pclk_o = 1'b0;
        fs_o   = 3'h0;
        dat_o  = 16'h0000;
        // 125 ns period stays under half the system clock
        forever #62.5 pclk_o = active ? ~pclk_o : 1'b0;
    end
    // words change on the falling edge; the clock stands still between frames
    task automatic send(input logic [15:0] w[$], input logic sync);
        active = 1'b1;
        repeat (3) @(negedge pclk_o);
        foreach (w[i]) begin
            fs_o[0] = sync && (i == 0);
            dat_o   = w[i];
            @(negedge pclk_o);
        end
        active = 1'b0;
        fs_o   = 3'h0;
        dat_o  = ~dat_o;
    endtask
endmodule

// file: bench/parallel_capture_port_bench.sv
// self-checking bench for the parallel capture port
`timescale 1ns/100ps
`include "pcp_cfg.svh"
module parallel_capture_port_bench
    import pcp_pkg::*;
;
    typedef logic [15:0] pcp_wq_type[$];
    logic        clk_i, port_clock_in_i, rx_valid_o, tx_ready_o, frame_done_o;
    logic        overrun_o, underrun_o, field_locked_o;
    logic        rst_n_i = 1'b0, port_enable_i = 1'b0, rx_ready_i = 1'b0, tx_valid_i = 1'b0;
    logic [2:0]  port_mode_i = 3'h0, data_width_i = 3'h0, fs_drive_en_i = 3'h5;
    logic [2:0]  frame_sync_i, frame_sync_o, frame_sync_oe_o, far_fs;
    logic [15:0] data_i, data_o, data_oe_o, far_dat, rx_data_o, tx_data_i = 16'h0000;
    logic [15:0] start_delay_reg_i = 16'h0000, sample_count_reg_i = 16'h0000;
    logic [15:0] line_length_i = 16'h0004, frame_lines_i = 16'h0002;
    int          bad_count = 0, check_count = 0, cyc = 0, n_done = 0, n_ovr = 0;
    int          n_und = 0, n_hs = 0;
    logic        hs_prev = 1'b0;
    logic [15:0] last_out = 16'h0000;
    pcp_wq_type  got;

    parallel_capture_port DUT (.clk_i, .rst_n_i, .port_clock_in_i, .frame_sync_i, .frame_sync_o,
        .frame_sync_oe_o, .data_i, .data_o, .data_oe_o, .port_enable_i, .port_mode_i,
        .data_width_i, .fs_drive_en_i, .start_delay_reg_i, .sample_count_reg_i, .line_length_i,
        .frame_lines_i, .rx_valid_o, .rx_ready_i, .rx_data_o, .tx_valid_i, .tx_ready_o,
        .tx_data_i, .frame_done_o, .overrun_o, .underrun_o, .field_locked_o);
    pcp_far_model P (.pclk_o(port_clock_in_i), .fs_o(far_fs), .dat_o(far_dat));
    // each pin follows whichever side has its driver enabled
    assign frame_sync_i = (frame_sync_oe_o & frame_sync_o) | (~frame_sync_oe_o & far_fs);
    assign data_i       = (data_oe_o & data_o) | (~data_oe_o & far_dat);

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (rx_valid_o === 1'b1 && rx_ready_i === 1'b1) got.push_back(rx_data_o);
        if (frame_done_o === 1'b1) n_done++;
        if (overrun_o === 1'b1) n_ovr++;
        if (underrun_o === 1'b1) n_und++;
        if (frame_sync_o[0] === 1'b1 && hs_prev !== 1'b1) n_hs++;
        // output words are collected as they appear on the data pins
        if (port_mode_i == PCP_GP_OUT && data_o !== last_out) got.push_back(data_o);
        hs_prev  = frame_sync_o[0];
        last_out = data_o;
        if (cyc == 40000) begin
            bad_count++;
            finish_test();
        end
    end
////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        if (bad_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // mode only changes while the port is disabled, which also flushes the fifo
    task automatic setup(input logic [2:0] m, input logic [2:0] w, input int d, input int n,
                         input logic rdy);
        @(negedge clk_i);
        port_enable_i = 1'b0;
        repeat (2) @(negedge clk_i);
        port_mode_i        = m;
        data_width_i       = w;
        start_delay_reg_i  = 16'(d);
        sample_count_reg_i = 16'(n);
        rx_ready_i         = rdy;
        got.delete();
        n_done = 0;
        n_ovr  = 0;
        n_und  = 0;
        n_hs   = 0;
        @(negedge clk_i);
        port_enable_i = 1'b1;
    endtask
    // extra idle cycles catch words that should not have been passed on
    task automatic drain(input pcp_wq_type want);
        @(negedge clk_i);
        rx_ready_i = 1'b1;
        for (int k = 0; k < 200 && got.size() < want.size(); k++) @(negedge clk_i);
        repeat (40) @(negedge clk_i);
        check(16'(got.size()), 16'(want.size()));
        foreach (want[i]) if (i < got.size()) check(got[i], want[i]);
    endtask
    task automatic push(input logic [15:0] w);
        @(negedge clk_i);
        tx_valid_i = 1'b1;
        tx_data_i  = w;
        do @(posedge clk_i); while (tx_ready_o !== 1'b1);
        @(negedge clk_i);
        tx_valid_i = 1'b0;
    endtask
    function automatic pcp_wq_type ramp(input int first, input int n, input logic [15:0] mask);
        pcp_wq_type q;
        for (int j = first; j < first + n; j++) q.push_back((16'h5A30 + 16'(j)) & mask);
        return q;
    endfunction
    // field-two code, field-one start, one active line, then blanking words
    function automatic pcp_wq_type vq(input int first, input int n);
        logic [7:0] v[21] = '{8'hFF, 8'h00, 8'h00, 8'hD0, 8'hFF, 8'h00, 8'h00, 8'h80, 8'h33,
            8'h44, 8'hFF, 8'h00, 8'h00, 8'h90, 8'h55, 8'hFF, 8'h00, 8'h00, 8'hA0, 8'h66, 8'h77};
        pcp_wq_type q;
        for (int j = first; j < first + n; j++) q.push_back({8'h00, v[j]});
        return q;
    endfunction
    task automatic video(input logic [2:0] m, input int first, input int n);
        setup(m, `PCP_WID_8, 0, 1, 1'b1);
        P.send(vq(0, 21), 1'b0);
        drain(vq(first, n));
        check(16'(field_locked_o), 16'(m != PCP_ITU_ACTIVE));
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge clk_i);
        check({frame_sync_oe_o, rx_valid_o, tx_ready_o, 11'h000}, 16'h0000);
        check(data_oe_o, 16'h0000);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        // ten samples against an eight-word fifo: two are dropped
        setup(PCP_GP_IN, `PCP_WID_8, 2, 10, 1'b0);
        P.send(ramp(0, 14, 16'hFFFF), 1'b1);
        check({13'h0000, frame_sync_oe_o}, 16'h0000);
        check(data_oe_o, 16'h0000);
        drain(ramp(3, 8, 16'h00FF));
        check(16'(n_ovr), 16'h0002);
        check(16'(n_done), 16'h0001);
        for (int k = 0; k < 8; k++) begin
            setup(PCP_GP_IN, 3'(k), k % 2, 2, 1'b0);
            P.send(ramp(0, 5, 16'hFFFF), 1'b1);
            drain(ramp(1 + k % 2, 2, 16'((1 << (k == 0 ? 8 : 9 + k)) - 1)));
        end
        // four-clock lines: the line start after the leading clocks triggers two samples
        setup(PCP_GP_CAPTURE, `PCP_WID_8, 0, 2, 1'b1);
        P.send(ramp(0, 4, 16'hFFFF), 1'b0);
        check({14'h0000, frame_sync_oe_o[1:0]}, 16'h0003);
        check(data_oe_o, 16'h0000);
        drain(ramp(2, 2, 16'h00FF));
        check(16'(n_hs), 16'h0002);
        check(16'(n_done), 16'h0001);
        setup(PCP_GP_OUT, `PCP_WID_10, 0, 2, 1'b0);
        push(16'h5A30);
        push(16'h5A31);
        P.send(ramp(0, 12, 16'hFFFF), 1'b0);
        check({13'h0000, frame_sync_oe_o}, 16'h0005);
        check(data_oe_o, 16'h03FF);
        drain(ramp(0, 2, 16'h03FF));
        check(16'(n_und), 16'h0004);
        check(16'(n_done), 16'h0003);
        video(PCP_ITU_FIELD, 8, 13);
        video(PCP_ITU_ACTIVE, 8, 2);
        check(16'(n_done), 16'h0001);
        video(PCP_ITU_VBI, 19, 2);
        finish_test();
    end
endmodule
